/* File: hw/cnc_pkg.sv */
// cnc_pkg: register map, field positions and codes of the CAN controller.
// assumes 12-bit byte addressing of 32-bit register words.
package cnc_pkg;
	localparam int NBUF = 32;
	localparam int HIST_DEPTH = 4;

	// register byte addresses
	localparam logic [11:0] A_GCTRL = 12'h000;
	localparam logic [11:0] A_MCTRL = 12'h004;
	localparam logic [11:0] A_PRESC = 12'h008;
	localparam logic [11:0] A_BTIME = 12'h00c;
	localparam logic [11:0] A_MASK = 12'h010;
	localparam logic [11:0] A_IEN = 12'h014;
	localparam logic [11:0] A_ERRC = 12'h018;
	localparam logic [11:0] A_INFO = 12'h01c;
	localparam logic [11:0] A_LEC = 12'h020;
	localparam logic [11:0] A_ISTAT = 12'h024;
	localparam logic [11:0] A_LTX = 12'h028;
	localparam logic [11:0] A_RHIST = 12'h02c;
	localparam logic [11:0] A_LRX = 12'h030;
	localparam logic [11:0] A_TRIG = 12'h034;

	// buffer window: addr[11:10] region, addr[9:5] buffer, addr[4:2] word
	localparam logic [1:0] BUF_REGION = 2'h1;
	localparam logic [2:0] W_CONF = 3'h0;
	localparam logic [2:0] W_ID = 3'h1;
	localparam logic [2:0] W_LEN = 3'h2;
	localparam logic [2:0] W_DLO = 3'h3;
	localparam logic [2:0] W_DHI = 3'h4;
	localparam logic [2:0] W_CTRL = 3'h5;

	// field positions
	localparam int GC_GOM = 0;
	localparam int GC_FORCED_SHUTDOWN_ENABLE = 1;
	localparam int MC_TRANSMIT_ACTIVE_STATUS = 8;
	localparam int MC_BUS_OFF_FLAG = 9;
	localparam int MC_ERROR_COUNTER_CLEAR_CMD = 15;
	localparam int CONF_ASG = 3;
	localparam int CT_RDY = 0;
	localparam int CT_TRQ = 1;
	localparam int CT_DN = 2;
	localparam int CT_MUC = 3;
	localparam int CT_SET = 16;
	localparam int IS_TX = 0;
	localparam int IS_RX = 1;
	localparam int IS_ERRST = 2;
	localparam int IS_PROT = 3;
	localparam int IS_ARB = 4;
	localparam int RH_OVF = 8;
	localparam int RH_EMPTY = 9;

	// operating modes
	typedef enum logic [2:0] {
		MODE_INIT = 3'h0,
		MODE_NORMAL = 3'h1,
		MODE_ABT = 3'h2,
		MODE_RXONLY = 3'h3,
		MODE_SSHOT = 3'h4,
		MODE_SELFTEST = 3'h5
	} cnc_mode_t;

	// buffer type codes
	localparam logic [2:0] TYPE_TX = 3'h0;
	localparam logic [2:0] TYPE_RX_LO = 3'h1;
	localparam logic [2:0] TYPE_RX_HI = 3'h5;

	localparam logic [4:0] ABT_LAST = 5'h7;
	localparam logic [7:0] TX_BASE_BITS = 8'h2f;
	localparam logic [4:0] TQ_FIXED = 5'h03;
	localparam logic [3:0] LEN_MAX = 4'h8;
endpackage

/* File: hw/cnc_payload_mem.sv */
// cnc_payload_mem: payload store, two words per buffer, registered read port.
// assumes one write per cycle; the read register also carries register reads.
`timescale 1ns/1ps
module cnc_payload_mem (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// write port
	input wire logic we_i,
	input wire logic [5:0] waddr_i,
	input wire logic [31:0] wdata_i,
	// read port
	input wire logic re_i,
	input wire logic sel_mem_i,
	input wire logic [5:0] raddr_i,
	input wire logic [31:0] bypass_i,
	output logic [31:0] rdata_o
);
	logic [31:0] mem [0:63];
	logic [31:0] rdata_next;

	always_comb begin
		rdata_next = 32'h0;
		if (re_i) begin
			rdata_next = sel_mem_i ? mem[raddr_i] : bypass_i;
		end
	end

	// payload has no reset; only the read register is cleared
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0;
		end else begin
			rdata_o <= rdata_next;
		end
	end
endmodule

/* File: hw/cnc_ctrl.sv */
// cnc_ctrl: register file, buffer flags, transmit scheduler and receive store.
// assumes a protocol core beside it that serialises frames and reports events.
// How it works
// - type codes one through five mark receive buffers.
// - type code zero marks a transmit buffer.
// - last transmitted pointer names the buffer sent; else abort succeeded.
// - updating and new data flags read together; data valid when both zero.
// - error state and protocol error statuses with info and error code.
`timescale 1ns/1ps
module cnc_ctrl (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// protocol core events
	input wire logic rx_valid_i,
	input wire logic [28:0] rx_id_i,
	input wire logic [3:0] rx_len_i,
	input wire logic [63:0] rx_data_i,
	input wire logic arb_lost_i,
	input wire logic prot_err_i,
	input wire logic [2:0] prot_err_code_i,
	input wire logic [1:0] err_state_i,
	input wire logic bus_off_i,
	input wire logic [15:0] err_cnt_i,
	// protocol core commands
	output logic tx_req_o,
	output logic [4:0] tx_buf_o,
	output logic tx_active_o,
	output logic err_clr_o
);
	localparam int N = cnc_pkg::NBUF;
	typedef enum logic [0:0] {T_IDLE = 1'b0, T_BUSY = 1'b1} cnc_tx_t;
	typedef enum logic [1:0] {R_IDLE = 2'b00, R_LO = 2'b01, R_HI = 2'b10} cnc_rx_t;

	function automatic logic is_tx(input logic [2:0] t);
		return t == cnc_pkg::TYPE_TX;
	endfunction
	function automatic logic is_rx(input logic [2:0] t);
		return t >= cnc_pkg::TYPE_RX_LO && t <= cnc_pkg::TYPE_RX_HI;
	endfunction
	function automatic logic [4:0] first_set(input logic [N-1:0] v);
		logic [4:0] r;
		r = 5'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) r = 5'(i);
		end
		return r;
	endfunction

	// control and status state
	logic gom_reg, gom_next, forced_shutdown_enable_reg, forced_shutdown_enable_next, trig_reg, trig_next, eclr_reg, eclr_next;
	cnc_pkg::cnc_mode_t mode_reg, mode_next;
	logic [7:0] presc_reg, presc_next, ien_reg, ien_next;
	logic [15:0] btime_reg, btime_next;
	logic [28:0] mask_reg, mask_next;
	logic [4:0] istat_reg, istat_next, ltx_reg, ltx_next, lrx_reg, lrx_next;
	logic [2:0] lec_reg, lec_next;
	logic [1:0] info_reg, info_next;
	// buffer flags
	logic [2:0] type_reg [N], type_next [N];
	logic [28:0] id_reg [N], id_next [N];
	logic [3:0] len_reg [N], len_next [N];
	logic [N-1:0] asg_reg, asg_next, rdy_reg, rdy_next, trq_reg, trq_next;
	logic [N-1:0] dn_reg, dn_next, muc_reg, muc_next;
	// history list
	localparam int HIST = cnc_pkg::HIST_DEPTH;
	logic [4:0] hist_reg [HIST], hist_next [HIST];
	logic [1:0] hwp_reg, hwp_next, hrp_reg, hrp_next;
	logic [2:0] hcnt_reg, hcnt_next;
	logic hovf_reg, hovf_next;
	// transmit and receive engines
	cnc_tx_t tst_reg, tst_next;
	cnc_rx_t rst_reg, rst_next;
	logic [4:0] tbuf_reg, tbuf_next, rbuf_reg, rbuf_next;
	logic [15:0] tq_reg, tq_next;
	logic [7:0] bits_reg, bits_next;
	logic treq_reg, treq_next;
	logic [63:0] rdat_reg, rdat_next;
	logic [28:0] rid_reg, rid_next;
	logic [3:0] rlen_reg, rlen_next;

	// decode
	logic bsel, mwe, tx_done, arb_evt, rx_hit, rx_done, ok_run, hpop;
	logic [4:0] bm;
	logic [2:0] bw;
	logic [N-1:0] cand, match;
	logic [15:0] bit_cyc;
	logic [31:0] byp, mwd;
	logic [5:0] mwa;

	assign bsel = addr_i[11:10] == cnc_pkg::BUF_REGION;
	assign bm = addr_i[9:5];
	assign bw = addr_i[4:2];
	assign ok_run = gom_reg && mode_reg != cnc_pkg::MODE_INIT && !bus_off_i;
	assign bit_cyc = 16'((presc_reg + 9'h1) * (btime_reg[3:0] + btime_reg[10:8] + cnc_pkg::TQ_FIXED));
	assign hpop = rd_i && addr_i == cnc_pkg::A_RHIST && hcnt_reg != 3'h0;

	always_comb begin
		for (int i = 0; i < N; i++) begin
			cand[i] = rdy_reg[i] && trq_reg[i] && asg_reg[i] && is_tx(type_reg[i]) &&
				(mode_reg != cnc_pkg::MODE_ABT || 5'(i) > cnc_pkg::ABT_LAST || trig_reg);
			match[i] = rdy_reg[i] && asg_reg[i] && is_rx(type_reg[i]) &&
				((id_reg[i] ^ rx_id_i) & ~mask_reg) == 29'h0;
		end
	end

	// transmit scheduler: one frame at a time, lowest buffer number first
	always_comb begin
		tst_next = tst_reg;
		tbuf_next = tbuf_reg;
		tq_next = tq_reg;
		bits_next = bits_reg;
		treq_next = 1'b0;
		tx_done = 1'b0;
		arb_evt = 1'b0;
		case (tst_reg)
			T_IDLE: begin
				if (ok_run && mode_reg != cnc_pkg::MODE_RXONLY && |cand) begin
					tbuf_next = first_set(cand);
					treq_next = 1'b1;
					tq_next = bit_cyc - 16'h1;
					bits_next = cnc_pkg::TX_BASE_BITS + {1'b0, len_reg[first_set(cand)], 3'h0};
					tst_next = T_BUSY;
				end
			end
			T_BUSY: begin
				// a started frame runs until sent, lost in arbitration or gom drops; clearing the request cannot cut it
				if (arb_lost_i) begin
					arb_evt = 1'b1;
					tst_next = T_IDLE;
				end else if (!gom_reg) begin
					tst_next = T_IDLE;
				end else if (tq_reg != 16'h0) begin
					tq_next = tq_reg - 16'h1;
				end else if (bits_reg == 8'h1) begin
					tx_done = 1'b1;
					tst_next = T_IDLE;
				end else begin
					bits_next = bits_reg - 8'h1;
					tq_next = bit_cyc - 16'h1;
				end
			end
			default: tst_next = T_IDLE;
		endcase
	end

	// receive store: payload written in two cycles with the updating flag up
	always_comb begin
		rst_next = rst_reg;
		rbuf_next = rbuf_reg;
		rdat_next = rdat_reg;
		rid_next = rid_reg;
		rlen_next = rlen_reg;
		rx_hit = 1'b0;
		rx_done = 1'b0;
		mwe = wr_i && bsel && (bw == cnc_pkg::W_DLO || bw == cnc_pkg::W_DHI);
		mwa = {bm, bw == cnc_pkg::W_DHI};
		mwd = wdata_i;
		case (rst_reg)
			R_IDLE: begin
				// frames that arrive while a store is busy are dropped
				if (rx_valid_i && ok_run && |match) begin
					rx_hit = 1'b1;
					rbuf_next = first_set(match);
					rdat_next = rx_data_i;
					rid_next = rx_id_i;
					rlen_next = rx_len_i;
					rst_next = R_LO;
				end
			end
			R_LO: begin
				if (!mwe) begin
					mwe = 1'b1;
					mwa = {rbuf_reg, 1'b0};
					mwd = rdat_reg[31:0];
					rst_next = R_HI;
				end
			end
			R_HI: begin
				if (!mwe) begin
					mwe = 1'b1;
					mwa = {rbuf_reg, 1'b1};
					mwd = rdat_reg[63:32];
					rx_done = 1'b1;
					rst_next = R_IDLE;
				end
			end
			default: rst_next = R_IDLE;
		endcase
	end

	// register writes and hardware events
	always_comb begin
		gom_next = gom_reg;
		forced_shutdown_enable_next = forced_shutdown_enable_reg;
		mode_next = mode_reg;
		presc_next = presc_reg;
		btime_next = btime_reg;
		mask_next = mask_reg;
		ien_next = ien_reg;
		trig_next = trig_reg;
		eclr_next = 1'b0;
		ltx_next = ltx_reg;
		lrx_next = lrx_reg;
		info_next = err_state_i;
		lec_next = lec_reg;
		istat_next = istat_reg;
		type_next = type_reg;
		id_next = id_reg;
		len_next = len_reg;
		asg_next = asg_reg;
		rdy_next = rdy_reg;
		trq_next = trq_reg;
		dn_next = dn_reg;
		muc_next = muc_reg;
		hist_next = hist_reg;
		hwp_next = hwp_reg;
		hrp_next = hrp_reg;
		hovf_next = hovf_reg;
		if (tx_done || (arb_evt && mode_reg == cnc_pkg::MODE_SSHOT)) trq_next[tbuf_reg] = 1'b0;
		if (wr_i && !bsel) begin
			case (addr_i)
				cnc_pkg::A_GCTRL: begin
					if (wdata_i[cnc_pkg::GC_FORCED_SHUTDOWN_ENABLE] && gom_reg) forced_shutdown_enable_next = 1'b1;
					if (wdata_i[cnc_pkg::GC_GOM]) begin
						gom_next = 1'b1;
					end else if (mode_reg == cnc_pkg::MODE_INIT || forced_shutdown_enable_reg) begin
						gom_next = 1'b0;
						forced_shutdown_enable_next = 1'b0;
						mode_next = cnc_pkg::MODE_INIT;
					end
				end
				cnc_pkg::A_MCTRL: begin
					if (wdata_i[2:0] <= cnc_pkg::MODE_SELFTEST) mode_next = cnc_pkg::cnc_mode_t'(wdata_i[2:0]);
					// counter clear only takes effect from init mode
					if (wdata_i[cnc_pkg::MC_ERROR_COUNTER_CLEAR_CMD] && mode_reg == cnc_pkg::MODE_INIT) eclr_next = 1'b1;
				end
				cnc_pkg::A_PRESC: presc_next = wdata_i[7:0];
				cnc_pkg::A_BTIME: btime_next = wdata_i[15:0];
				cnc_pkg::A_MASK: mask_next = wdata_i[28:0];
				cnc_pkg::A_IEN: ien_next = wdata_i[7:0];
				cnc_pkg::A_LEC: lec_next = 3'h0;
				cnc_pkg::A_ISTAT: istat_next = istat_reg & ~wdata_i[4:0];
				cnc_pkg::A_RHIST: if (wdata_i[cnc_pkg::RH_OVF]) hovf_next = 1'b0;
				cnc_pkg::A_TRIG: trig_next = wdata_i[0];
				default: ;
			endcase
		end
		if (wr_i && bsel) begin
			case (bw)
				// configuration and identifier hold while the buffer is ready
				cnc_pkg::W_CONF: if (!rdy_reg[bm]) begin
					type_next[bm] = wdata_i[2:0];
					asg_next[bm] = wdata_i[cnc_pkg::CONF_ASG];
				end
				cnc_pkg::W_ID: if (!rdy_reg[bm]) id_next[bm] = wdata_i[28:0];
				cnc_pkg::W_LEN: if (!rdy_reg[bm]) len_next[bm] = wdata_i[3:0];
				cnc_pkg::W_CTRL: begin
					rdy_next[bm] = (rdy_reg[bm] & ~wdata_i[cnc_pkg::CT_RDY]) | wdata_i[cnc_pkg::CT_SET + cnc_pkg::CT_RDY];
					trq_next[bm] = (trq_next[bm] & ~wdata_i[cnc_pkg::CT_TRQ]) | wdata_i[cnc_pkg::CT_SET + cnc_pkg::CT_TRQ];
					dn_next[bm] = (dn_reg[bm] & ~wdata_i[cnc_pkg::CT_DN]) | wdata_i[cnc_pkg::CT_SET + cnc_pkg::CT_DN];
				end
				default: ;
			endcase
		end
		if (tx_done) ltx_next = tbuf_reg;
		if (rx_hit) muc_next[rbuf_next] = 1'b1;
		if (rx_done) begin
			muc_next[rbuf_reg] = 1'b0;
			dn_next[rbuf_reg] = 1'b1;
			id_next[rbuf_reg] = rid_reg;
			len_next[rbuf_reg] = rlen_reg;
			lrx_next = rbuf_reg;
			if (hcnt_reg == 3'(HIST)) begin
				hovf_next = 1'b1;
			end else begin
				hist_next[hwp_reg] = rbuf_reg;
				hwp_next = hwp_reg + 2'h1;
			end
		end
		if (hpop) hrp_next = hrp_reg + 2'h1;
		hcnt_next = hcnt_reg + 3'(rx_done && hcnt_reg != 3'(HIST)) - 3'(hpop);
		// block trigger drops once no block-area request is left
		if (trig_reg && tst_reg == T_IDLE && cand[7:0] == 8'h0) trig_next = 1'b0;
		if (prot_err_i) lec_next = prot_err_code_i;
		// hardware events win over a clear in the same cycle
		istat_next = istat_next | {arb_evt, prot_err_i, err_state_i != info_reg, rx_done, tx_done};
	end

	// read data source for everything but payload
	always_comb begin
		byp = 32'h0;
		if (bsel) begin
			case (bw)
				cnc_pkg::W_CONF: byp = {28'h0, asg_reg[bm], type_reg[bm]};
				cnc_pkg::W_ID: byp = {3'h0, id_reg[bm]};
				cnc_pkg::W_LEN: byp = {28'h0, len_reg[bm]};
				cnc_pkg::W_CTRL: byp = {28'h0, muc_reg[bm], dn_reg[bm], trq_reg[bm], rdy_reg[bm]};
				default: byp = 32'h0;
			endcase
		end else begin
			case (addr_i)
				cnc_pkg::A_GCTRL: byp = {30'h0, forced_shutdown_enable_reg, gom_reg};
				cnc_pkg::A_MCTRL: byp = {22'h0, bus_off_i, tst_reg == T_BUSY, 5'h0, mode_reg};
				cnc_pkg::A_PRESC: byp = {24'h0, presc_reg};
				cnc_pkg::A_BTIME: byp = {16'h0, btime_reg};
				cnc_pkg::A_MASK: byp = {3'h0, mask_reg};
				cnc_pkg::A_IEN: byp = {24'h0, ien_reg};
				cnc_pkg::A_ERRC: byp = {16'h0, err_cnt_i};
				cnc_pkg::A_INFO: byp = {30'h0, info_reg};
				cnc_pkg::A_LEC: byp = {29'h0, lec_reg};
				cnc_pkg::A_ISTAT: byp = {27'h0, istat_reg};
				cnc_pkg::A_LTX: byp = {27'h0, ltx_reg};
				cnc_pkg::A_RHIST: byp = {22'h0, hcnt_reg == 3'h0, hovf_reg, 3'h0, hist_reg[hrp_reg]};
				cnc_pkg::A_LRX: byp = {27'h0, lrx_reg};
				cnc_pkg::A_TRIG: byp = {31'h0, trig_reg};
				default: byp = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gom_reg <= 1'b0; forced_shutdown_enable_reg <= 1'b0; trig_reg <= 1'b0; eclr_reg <= 1'b0;
			mode_reg <= cnc_pkg::MODE_INIT; presc_reg <= 8'h0; ien_reg <= 8'h0;
			btime_reg <= 16'h0; mask_reg <= 29'h0; istat_reg <= 5'h0; ltx_reg <= 5'h0;
			lrx_reg <= 5'h0; lec_reg <= 3'h0; info_reg <= 2'h0;
			asg_reg <= '0; rdy_reg <= '0; trq_reg <= '0; dn_reg <= '0; muc_reg <= '0;
			for (int i = 0; i < N; i++) begin
				type_reg[i] <= cnc_pkg::TYPE_TX; id_reg[i] <= 29'h0; len_reg[i] <= 4'h0;
			end
			for (int i = 0; i < HIST; i++) hist_reg[i] <= 5'h0;
			hwp_reg <= 2'h0; hrp_reg <= 2'h0; hcnt_reg <= 3'h0; hovf_reg <= 1'b0;
			tst_reg <= T_IDLE; rst_reg <= R_IDLE; tbuf_reg <= 5'h0; rbuf_reg <= 5'h0;
			tq_reg <= 16'h0; bits_reg <= 8'h0; treq_reg <= 1'b0;
			rdat_reg <= 64'h0; rid_reg <= 29'h0; rlen_reg <= 4'h0;
		end else begin
			gom_reg <= gom_next; forced_shutdown_enable_reg <= forced_shutdown_enable_next; trig_reg <= trig_next; eclr_reg <= eclr_next;
			mode_reg <= mode_next; presc_reg <= presc_next; ien_reg <= ien_next;
			btime_reg <= btime_next; mask_reg <= mask_next; istat_reg <= istat_next;
			ltx_reg <= ltx_next; lrx_reg <= lrx_next; lec_reg <= lec_next; info_reg <= info_next;
			asg_reg <= asg_next; rdy_reg <= rdy_next; trq_reg <= trq_next; dn_reg <= dn_next;
			muc_reg <= muc_next; type_reg <= type_next; id_reg <= id_next; len_reg <= len_next;
			hist_reg <= hist_next; hwp_reg <= hwp_next; hrp_reg <= hrp_next;
			hcnt_reg <= hcnt_next; hovf_reg <= hovf_next;
			tst_reg <= tst_next; rst_reg <= rst_next; tbuf_reg <= tbuf_next; rbuf_reg <= rbuf_next;
			tq_reg <= tq_next; bits_reg <= bits_next; treq_reg <= treq_next;
			rdat_reg <= rdat_next; rid_reg <= rid_next; rlen_reg <= rlen_next;
		end
	end

	assign tx_req_o = treq_reg;
	assign tx_buf_o = tbuf_reg;
	assign tx_active_o = tst_reg == T_BUSY;
	assign err_clr_o = eclr_reg;

	cnc_payload_mem u_mem (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.we_i(mwe),
		.waddr_i(mwa),
		.wdata_i(mwd),
		.re_i(rd_i),
		.sel_mem_i(bsel && (bw == cnc_pkg::W_DLO || bw == cnc_pkg::W_DHI)),
		.raddr_i({bm, bw == cnc_pkg::W_DHI}),
		.bypass_i(byp),
		.rdata_o(rdata_o)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	tx_type_a: assert property (tx_req_o |-> is_tx(type_reg[tx_buf_o])) else $error("tx of non-tx buffer");
	rx_type_a: assert property (rx_done |-> is_rx(type_reg[rbuf_reg])) else $error("rx into non-rx buffer");
	last_tx_a: assert property (tx_done |=> ltx_reg == $past(tbuf_reg) && !tx_active_o) else $error("last tx pointer wrong");
	muc_win_a: assert property (rx_hit |=> muc_reg[rbuf_reg] && !rx_done ##1 muc_reg[rbuf_reg]) else $error("updating flag low during store");
	dn_set_a: assert property (rx_done |=> dn_reg[$past(rbuf_reg)] && !muc_reg[$past(rbuf_reg)]) else $error("new data not posted");
	shut_both_a: assert property (wr_i && addr_i == cnc_pkg::A_GCTRL &&
		!wdata_i[cnc_pkg::GC_GOM] && forced_shutdown_enable_reg |=> !gom_reg && !forced_shutdown_enable_reg)
		else $error("forced shutdown incomplete");
	forced_shutdown_enable_clr_a: assert property (forced_shutdown_enable_reg |-> gom_reg) else $error("shutdown enable outlived operation");
	prot_err_a: assert property (prot_err_i |=> lec_reg == $past(prot_err_code_i) && istat_reg[cnc_pkg::IS_PROT]) else $error("protocol error lost");
	err_state_a: assert property (err_state_i != info_reg |=> istat_reg[cnc_pkg::IS_ERRST] && info_reg == $past(err_state_i)) else $error("error state change lost");
	tx_done_c: cover property (tx_done);
	rx_done_c: cover property (rx_done);
	shutdown_c: cover property (forced_shutdown_enable_reg ##1 !gom_reg);
	hist_ovf_c: cover property ($rose(hovf_reg));
endmodule

/* File: verif/cnc_core_model.sv */
// cnc_core_model: stand-in for the protocol core beside the controller.
// assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module cnc_core_model (
	// clock
	input wire logic clk_i,
	// commands from the controller
	input wire logic tx_req_i,
	input wire logic err_clr_i,
	// events to the controller
	output logic rx_valid_o,
	output logic [28:0] rx_id_o,
	output logic [3:0] rx_len_o,
	output logic [63:0] rx_data_o,
	output logic arb_lost_o,
	output logic prot_err_o,
	output logic [2:0] prot_err_code_o,
	output logic [1:0] err_state_o,
	output logic bus_off_o,
	output logic [15:0] err_cnt_o
);
	int tx_cnt = 0;
	int clr_cnt = 0;
	initial begin
		rx_valid_o = 1'b0;
		rx_id_o = '0;
		rx_len_o = '0;
		rx_data_o = '0;
		arb_lost_o = 1'b0;
		prot_err_o = 1'b0;
		prot_err_code_o = '0;
		err_state_o = '0;
		bus_off_o = 1'b0;
		err_cnt_o = 16'h0102;
	end
	always @(posedge clk_i) begin
		if (tx_req_i === 1'b1)
			tx_cnt++;
		if (err_clr_i === 1'b1)
			clr_cnt++;
	end
	task automatic frame(input logic [28:0] id, input logic [3:0] len, input logic [63:0] d);
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_id_o <= id;
		rx_len_o <= len;
		rx_data_o <= d;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		// stale lines are inverted so a late capture shows up
		rx_id_o <= ~id;
		rx_len_o <= ~len;
		rx_data_o <= ~d;
	endtask
	task automatic fault(input logic arb, input logic [2:0] code, input logic [1:0] st);
		@(posedge clk_i);
		arb_lost_o <= arb;
		prot_err_o <= !arb;
		prot_err_code_o <= code;
		err_state_o <= st;
		@(posedge clk_i);
		arb_lost_o <= 1'b0;
		prot_err_o <= 1'b0;
		prot_err_code_o <= ~code;
	endtask
	task automatic set_bus_off(input logic v);
		@(posedge clk_i);
		bus_off_o <= v;
	endtask
endmodule

/* File: verif/tb_cnc_ctrl.sv */
// tb_cnc_ctrl: register-level scenarios for the controller.
// assumes cnc_ctrl instantiates its payload store itself.
`timescale 1ns/1ps
module tb_cnc_ctrl;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [11:0] addr_i = '0;
	logic [31:0] wdata_i = '0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic rx_valid_i, arb_lost_i, prot_err_i, bus_off_i;
	logic [28:0] rx_id_i;
	logic [3:0] rx_len_i;
	logic [63:0] rx_data_i;
	logic [2:0] prot_err_code_i;
	logic [1:0] err_state_i;
	logic [15:0] err_cnt_i;
	logic tx_req_o, tx_active_o, err_clr_o;
	logic [4:0] tx_buf_o;
	int num_errors = 0;
	int checked = 0;
	always #12.5 clk_i = ~clk_i;
	cnc_ctrl cnc_ctrl_inst (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.rx_valid_i, .rx_id_i, .rx_len_i, .rx_data_i, .arb_lost_i, .prot_err_i,
		.prot_err_code_i, .err_state_i, .bus_off_i, .err_cnt_i, .tx_req_o, .tx_buf_o,
		.tx_active_o, .err_clr_o);
	cnc_core_model cnc_core_model_inst (.clk_i(clk_i), .tx_req_i(tx_req_o),
		.err_clr_i(err_clr_o), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i),
		.rx_len_o(rx_len_i), .rx_data_o(rx_data_i), .arb_lost_o(arb_lost_i),
		.prot_err_o(prot_err_i), .prot_err_code_o(prot_err_code_i),
		.err_state_o(err_state_i), .bus_off_o(bus_off_i), .err_cnt_o(err_cnt_i));
	task automatic results();
		$display("comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rc(input string what, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(what, exp, rdata_o & m);
	endtask
	function automatic logic [11:0] ba(input logic [4:0] m, input logic [2:0] w);
		return {cnc_pkg::BUF_REGION, m, w, 2'h0};
	endfunction
	// bounded wait for the transmit-active level; a hang ends the run
	task automatic wait_tx(input logic lvl);
		int n;
		for (n = 0; n < 1000; n++) begin
			#1;
			if (tx_active_o === lvl)
				break;
			@(posedge clk_i);
		end
		if (n == 1000) begin
			num_errors++;
			results();
		end
	endtask
	task automatic setup(input logic [4:0] m, input logic [31:0] conf, input logic [31:0] id);
		wr(ba(m, cnc_pkg::W_CTRL), 32'h1);
		rc("ready clear", ba(m, cnc_pkg::W_CTRL), 32'h1, 32'h0);
		wr(ba(m, cnc_pkg::W_CONF), conf);
		wr(ba(m, cnc_pkg::W_ID), id);
		wr(ba(m, cnc_pkg::W_LEN), 32'h0);
		wr(ba(m, cnc_pkg::W_DLO), 32'h0);
		wr(ba(m, cnc_pkg::W_DHI), 32'h0);
		wr(ba(m, cnc_pkg::W_CTRL), 32'h1_0000);
	endtask
	task automatic t_init();
		rc("global ctrl", cnc_pkg::A_GCTRL, 32'hffffffff, 32'h0);
		rc("unmapped", 12'h0fc, 32'hffffffff, 32'h0);
		wr(cnc_pkg::A_PRESC, 32'h0);
		wr(cnc_pkg::A_BTIME, 32'h0);
		wr(cnc_pkg::A_IEN, 32'hff);
		wr(cnc_pkg::A_MASK, 32'h0);
		wr(cnc_pkg::A_MCTRL, 32'h8000);
		wr(ba(5'h0, cnc_pkg::W_CONF), 32'h0);
		wr(cnc_pkg::A_MCTRL, 32'h1);
		// counter clear outside init must be ignored
		wr(cnc_pkg::A_MCTRL, 32'h8001);
		rc("mode", cnc_pkg::A_MCTRL, 32'h7, 32'h1);
		chk("counter clears", 32'(cnc_core_model_inst.clr_cnt), 32'h1);
		wr(cnc_pkg::A_GCTRL, 32'h1);
		$display("init done");
	endtask
	task automatic t_tx();
		setup(5'h2, 32'h8, 32'h123);
		wr(ba(5'h2, cnc_pkg::W_CONF), 32'h1);
		rc("locked conf", ba(5'h2, cnc_pkg::W_CONF), 32'hf, 32'h8);
		wr(ba(5'h2, cnc_pkg::W_CTRL), 32'h2_0000);
		wait_tx(1'b1);
		chk("tx buffer", {27'h0, tx_buf_o}, 32'h2);
		wait_tx(1'b0);
		chk("frames started", 32'(cnc_core_model_inst.tx_cnt), 32'h1);
		rc("last tx", cnc_pkg::A_LTX, 32'h1f, 32'h2);
		rc("tx flags", ba(5'h2, cnc_pkg::W_CTRL), 32'hf, 32'h1);
		rc("tx done", cnc_pkg::A_ISTAT, 32'h1, 32'h1);
		$display("transmit done");
	endtask
	task automatic t_abort();
		setup(5'h3, 32'h8, 32'h55);
		wr(ba(5'h3, cnc_pkg::W_CTRL), 32'h2_0000);
		wait_tx(1'b1);
		wr(ba(5'h3, cnc_pkg::W_CTRL), 32'h2);
		#1 chk("still active", {31'h0, tx_active_o}, 32'h1);
		cnc_core_model_inst.fault(1'b1, 3'h0, 2'h0);
		repeat (33) @(posedge clk_i);
		wait_tx(1'b0);
		rc("aborted", cnc_pkg::A_LTX, 32'h1f, 32'h2);
		rc("arb lost", cnc_pkg::A_ISTAT, 32'h10, 32'h10);
		setup(5'h4, 32'h8, 32'h56);
		wr(ba(5'h4, cnc_pkg::W_CTRL), 32'h2_0000);
		wait_tx(1'b1);
		wr(ba(5'h4, cnc_pkg::W_CTRL), 32'h2);
		wait_tx(1'b0);
		rc("sent anyway", cnc_pkg::A_LTX, 32'h1f, 32'h4);
		$display("abort done");
	endtask
	task automatic t_rx();
		setup(5'h1, 32'he, 32'h0abcdef);
		setup(5'h5, 32'hd, 32'h0abcdef);
		cnc_core_model_inst.frame(29'h0abcdef, 4'h4, 64'h8877665544332211);
		repeat (4) @(posedge clk_i);
		rc("rx flags", ba(5'h5, cnc_pkg::W_CTRL), 32'hf, 32'h5);
		rc("no rx type 6", ba(5'h1, cnc_pkg::W_CTRL), 32'hf, 32'h1);
		rc("history", cnc_pkg::A_RHIST, 32'h3ff, 32'h5);
		rc("data lo", ba(5'h5, cnc_pkg::W_DLO), 32'hffffffff, 32'h44332211);
		rc("rx length", ba(5'h5, cnc_pkg::W_LEN), 32'hf, 32'h4);
		wr(ba(5'h5, cnc_pkg::W_CTRL), 32'h4);
		rc("data settled", ba(5'h5, cnc_pkg::W_CTRL), 32'hc, 32'h0);
		rc("history empty", cnc_pkg::A_RHIST, 32'h200, 32'h200);
		$display("receive done");
	endtask
	task automatic t_err();
		wr(cnc_pkg::A_ISTAT, 32'h1f);
		cnc_core_model_inst.fault(1'b0, 3'h5, 2'h2);
		repeat (3) @(posedge clk_i);
		rc("error status", cnc_pkg::A_ISTAT, 32'hc, 32'hc);
		rc("module info", cnc_pkg::A_INFO, 32'h3, 32'h2);
		rc("error code", cnc_pkg::A_LEC, 32'h7, 32'h5);
		wr(cnc_pkg::A_ISTAT, 32'hc);
		rc("status cleared", cnc_pkg::A_ISTAT, 32'hc, 32'h0);
		$display("error handling done");
	endtask
	task automatic t_abt();
		cnc_core_model_inst.set_bus_off(1'b1);
		rc("bus off", cnc_pkg::A_MCTRL, 32'h200, 32'h200);
		wr(cnc_pkg::A_MCTRL, 32'h0);
		wr(ba(5'h6, cnc_pkg::W_CTRL), 32'h7);
		wr(cnc_pkg::A_MCTRL, 32'h8002);
		cnc_core_model_inst.set_bus_off(1'b0);
		wr(ba(5'h4, cnc_pkg::W_CTRL), 32'h2_0000);
		rc("held by trigger", cnc_pkg::A_MCTRL, 32'h107, 32'h2);
		chk("forced recovery", 32'(cnc_core_model_inst.clr_cnt), 32'h2);
		wr(cnc_pkg::A_TRIG, 32'h1);
		wait_tx(1'b1);
		chk("block buffer", {27'h0, tx_buf_o}, 32'h4);
		wr(cnc_pkg::A_TRIG, 32'h0);
		rc("trigger off", cnc_pkg::A_TRIG, 32'h1, 32'h0);
		wr(ba(5'h4, cnc_pkg::W_CTRL), 32'h2);
		repeat (33) @(posedge clk_i);
		wait_tx(1'b0);
		rc("block sent", cnc_pkg::A_LTX, 32'h1f, 32'h4);
		rc("no request", ba(5'h4, cnc_pkg::W_CTRL), 32'h2, 32'h0);
		wr(cnc_pkg::A_MCTRL, 32'h4);
		wr(ba(5'h2, cnc_pkg::W_CTRL), 32'h2_0000);
		wait_tx(1'b1);
		cnc_core_model_inst.fault(1'b1, 3'h0, 2'h2);
		wait_tx(1'b0);
		rc("single shot", ba(5'h2, cnc_pkg::W_CTRL), 32'h2, 32'h0);
		$display("block and single shot done");
	endtask
	task automatic t_shut();
		wr(cnc_pkg::A_GCTRL, 32'h0);
		rc("gom kept", cnc_pkg::A_GCTRL, 32'h3, 32'h1);
		wr(cnc_pkg::A_GCTRL, 32'h3);
		wr(cnc_pkg::A_GCTRL, 32'h0);
		rc("shut down", cnc_pkg::A_GCTRL, 32'h3, 32'h0);
		rc("back to init", cnc_pkg::A_MCTRL, 32'h7, 32'h0);
		$display("shutdown done");
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_init();
		t_tx();
		t_abort();
		t_rx();
		t_err();
		t_abt();
		t_shut();
		results();
	end
endmodule
